/* rtl/csc_pkg.sv */
package csc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_RESULT   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;

  // ----------------------------------------
  // control fields and reset values
  // ----------------------------------------
  localparam int          CTL_EN_BIT   = 0;
  localparam int          CTL_SEL_LSB  = 1;
  localparam int          CTL_SRC_BIT  = 4;
  localparam int          CTL_RSV_BIT  = 5;
  localparam logic [7:0]  CTL_RESET    = 8'h00;
  localparam logic [7:0]  RESULT_RESET = 8'h00;
  localparam int          IRQ_DONE_BIT = 0;
  localparam int          IRQ_LOST_BIT = 1;
  localparam int          IRQ_W        = 2;

  // ----------------------------------------
  // gate interval: exponents per select code
  // ----------------------------------------
  localparam int SEL_EXP_BASE = 3;
  localparam int SEL_EXP_STEP = 2;
  localparam int TB_W         = 18;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10,
    ST_LOST = 2'b11
  } mon_state_t;

  typedef struct packed {
    logic        en;
    logic [2:0]  sel;
    logic        src;
  } ctl_t;

  typedef struct packed {
    logic        gate;
    logic        gateRise;
    logic        gateFall;
  } gate_t;

endpackage : csc_pkg

/* rtl/gate_edge_detect.sv */
`timescale 1ns/1ps
module gate_edge_detect (
  input  wire logic                clk_sys,
  input  wire logic                rstSync_b,
  input  wire logic [csc_pkg::TB_W-1:0] tbCount,
  input  wire logic [2:0]          sel,
  output csc_pkg::gate_t           gateOut
);
  import csc_pkg::*;

  typedef struct packed {
    logic       prev;
    logic [2:0] sel;
  } st_t;

  st_t  st_r;
  st_t  st_nxt;
  logic lvl;

  // ----------------------------------------
  // tap select and edges
  // ----------------------------------------
  always_comb begin
    lvl             = tbCount[SEL_EXP_BASE + SEL_EXP_STEP * int'(sel) - 1];
    st_nxt.prev     = lvl;
    st_nxt.sel      = sel;
    // no edge in the cycle after a tap change
    gateOut.gate     = lvl;
    gateOut.gateRise = lvl & ~st_r.prev & (sel == st_r.sel);
    gateOut.gateFall = ~lvl & st_r.prev & (sel == st_r.sel);
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : gate_edge_detect

/* rtl/osc_edge_detect.sv */
`timescale 1ns/1ps
module osc_edge_detect (
  input  wire logic clk_sys,
  input  wire logic rstSync_b,
  input  wire logic oscIn,
  output logic      oscTick
);
  import csc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  // ----------------------------------------
  // two-flop sync and rise detect
  // ----------------------------------------
  always_comb begin
    st_nxt.s1 = oscIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    oscTick   = st_r.s2 & ~st_r.s3;
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : osc_edge_detect

/* rtl/clock_supervisor_counter_ctrl.sv */
`timescale 1ns/1ps
module clock_supervisor_counter_ctrl #(
  parameter int CNT_W = 8
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [csc_pkg::TB_W-1:0]     tbCount,
  input  wire logic                         tbRunning,
  input  wire logic                         mainOsc,
  input  wire logic                         subOsc,
  output logic                              irq
);
  import csc_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rstMeta;
  logic rstSync_b;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta   <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta   <= 1'b1;
      rstSync_b <= rstMeta;
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mon_state_t             state;
    ctl_t                   ctl;
    logic [CNT_W-1:0]       count;
    logic [CNT_W-1:0]       result;
    logic                   stalled;
    logic [IRQ_W-1:0]       irqStat;
    logic [IRQ_W-1:0]       irqEn;
    logic [31:0]            rdata;
  } st_t;

  st_t    st_r;
  st_t    st_nxt;
  gate_t  gateSig;
  logic   mainTick;
  logic   subTick;
  logic   oscTick;
  logic   wrEn;
  logic   rdEn;
  logic   hit;
  logic   swStart;
  logic   swStop;
  logic   windowEnd;
  logic [IRQ_W-1:0] irqSet;

  gate_edge_detect u_gate (
    .clk_sys   (clk_sys),
    .rstSync_b (rstSync_b),
    .tbCount   (tbCount),
    .sel       (st_r.ctl.sel),
    .gateOut   (gateSig)
  );

  osc_edge_detect u_main (
    .clk_sys   (clk_sys),
    .rstSync_b (rstSync_b),
    .oscIn     (mainOsc),
    .oscTick   (mainTick)
  );

  osc_edge_detect u_sub (
    .clk_sys   (clk_sys),
    .rstSync_b (rstSync_b),
    .oscIn     (subOsc),
    .oscTick   (subTick)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt    = st_r;
    oscTick   = st_r.ctl.src ? subTick : mainTick;
    wrEn      = psel & penable & pwrite;
    rdEn      = psel & ~penable & ~pwrite;
    hit       = (paddr == ADDR_CONTROL) || (paddr == ADDR_RESULT) ||
                (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_EN) ||
                (paddr == ADDR_IRQ_CLR);
    swStart   = wrEn && paddr == ADDR_CONTROL && pwdata[CTL_EN_BIT] && !st_r.ctl.en;
    swStop    = wrEn && paddr == ADDR_CONTROL && !pwdata[CTL_EN_BIT] && st_r.ctl.en;
    windowEnd = 1'b0;
    irqSet    = '0;

    // measurement sequencing
    unique case (st_r.state)
      ST_IDLE: begin
      end
      ST_WAIT: begin
        if (tbRunning && gateSig.gateRise) begin
          st_nxt.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tbRunning && gateSig.gateRise) begin
          if (st_r.stalled && !oscTick) begin
            st_nxt.state = ST_LOST;
          end else begin
            windowEnd = 1'b1;
          end
        end else if (tbRunning && oscTick) begin
          st_nxt.count   = st_r.count + 1'b1;
          st_nxt.stalled = 1'b0;
        end
      end
      ST_LOST: begin
        if (oscTick) begin
          st_nxt.count = st_r.count + 1'b1;
          windowEnd    = 1'b1;
        end else if (gateSig.gateFall) begin
          st_nxt.count      = '0;
          st_nxt.ctl.en     = 1'b0;
          st_nxt.state      = ST_IDLE;
          irqSet[IRQ_LOST_BIT] = 1'b1;
        end
      end
    endcase

    // stall marker: no oscillator edge since last gate fall
    if (st_r.state == ST_RUN && gateSig.gateFall && !oscTick) begin
      st_nxt.stalled = 1'b1;
    end

    if (windowEnd) begin
      st_nxt.result = (st_r.state == ST_LOST) ? st_nxt.count : st_r.count;
      st_nxt.ctl.en = 1'b0;
      st_nxt.state  = ST_IDLE;
      irqSet[IRQ_DONE_BIT] = 1'b1;
    end

    // register writes
    if (wrEn) begin
      unique case (paddr)
        ADDR_CONTROL: begin
          if (!st_r.ctl.en) begin
            st_nxt.ctl.src = pwdata[CTL_SRC_BIT];
            st_nxt.ctl.sel = pwdata[CTL_SEL_LSB +: 3];
          end
        end
        ADDR_IRQ_EN: st_nxt.irqEn = pwdata[IRQ_W-1:0];
        ADDR_IRQ_CLR: st_nxt.irqStat = st_r.irqStat & ~pwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    st_nxt.irqStat = st_nxt.irqStat | irqSet;

    if (swStart) begin
      st_nxt.ctl.en  = 1'b1;
      st_nxt.result  = '0;
      st_nxt.count   = '0;
      st_nxt.stalled = 1'b0;
      st_nxt.state   = ST_WAIT;
    end
    if (swStop) begin
      st_nxt.ctl.en = 1'b0;
      st_nxt.result = '0;
      st_nxt.count  = '0;
      st_nxt.state  = ST_IDLE;
    end

    // read data captured in setup phase
    if (rdEn) begin
      unique case (paddr)
        ADDR_CONTROL:
          st_nxt.rdata = {24'h000000, 2'b00, 1'b0, st_r.ctl.src, st_r.ctl.sel,
                          st_r.ctl.en};
        ADDR_RESULT:
          st_nxt.rdata = st_r.ctl.en ? 32'h00000000 :
                         {{(32-CNT_W){1'b0}}, st_r.result};
        ADDR_IRQ_STAT: st_nxt.rdata = {{(32-IRQ_W){1'b0}}, st_r.irqStat};
        ADDR_IRQ_EN:   st_nxt.rdata = {{(32-IRQ_W){1'b0}}, st_r.irqEn};
        default:       st_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st_r        <= '0;
      st_r.state  <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata  = st_r.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign irq     = |(st_r.irqStat & st_r.irqEn);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_start_clears;
    @(posedge clk_sys) disable iff (!rstSync_b)
      swStart |=> (st_r.result == '0 && st_r.ctl.en && st_r.state == ST_WAIT);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start not clean");

  property p_stop_clears;
    @(posedge clk_sys) disable iff (!rstSync_b)
      swStop |=> (st_r.result == '0 && !st_r.ctl.en && st_r.count == '0);
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stop not clean");

  property p_done_self_clear;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_RUN && gateSig.gateRise && tbRunning && !st_r.stalled && !swStop)
        |=> (!st_r.ctl.en && st_r.result == $past(st_r.count));
  endproperty
  a_done_self_clear: assert property (p_done_self_clear) else $error("no self clear");

  property p_wait_to_run;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_WAIT && gateSig.gateRise && tbRunning && !wrEn) |=> st_r.state == ST_RUN;
  endproperty
  a_wait_to_run: assert property (p_wait_to_run) else $error("window not opened");

  property p_tb_halt;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_RUN && !tbRunning && !wrEn) |=> $stable(st_r.count);
  endproperty
  a_tb_halt: assert property (p_tb_halt) else $error("count moved while halted");

  property p_lost_fall;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_LOST && gateSig.gateFall && !oscTick && !wrEn)
        |=> (!st_r.ctl.en && st_r.count == '0 && st_r.irqStat[IRQ_LOST_BIT]);
  endproperty
  a_lost_fall: assert property (p_lost_fall) else $error("lost clear missing");

  property p_lost_resume;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_LOST && oscTick && !wrEn) |=> (!st_r.ctl.en && st_r.state == ST_IDLE);
  endproperty
  a_lost_resume: assert property (p_lost_resume) else $error("resume no clear");

  property p_src_count;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_RUN && tbRunning && oscTick && !gateSig.gateRise && !wrEn)
        |=> st_r.count == $past(st_r.count) + 1'b1;
  endproperty
  a_src_count: assert property (p_src_count) else $error("count step wrong");

  property p_ctl_locked;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.ctl.en && !windowEnd && st_r.state != ST_LOST) |=>
        (st_r.ctl.sel == $past(st_r.ctl.sel) && st_r.ctl.src == $past(st_r.ctl.src));
  endproperty
  a_ctl_locked: assert property (p_ctl_locked) else $error("select changed while on");

  property p_result_masked;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (rdEn && paddr == ADDR_RESULT && st_r.ctl.en) |=> prdata == 32'h00000000;
  endproperty
  a_result_masked: assert property (p_result_masked) else $error("result visible");

  property p_stall_to_lost;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_RUN && gateSig.gateRise && tbRunning && st_r.stalled && !oscTick &&
       !wrEn) |=> st_r.state == ST_LOST;
  endproperty
  a_stall_to_lost: assert property (p_stall_to_lost) else $error("stall not caught");

  property p_ctl_top_zero;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (rdEn && paddr == ADDR_CONTROL) |=> prdata[31:5] == 27'h0000000;
  endproperty
  a_ctl_top_zero: assert property (p_ctl_top_zero) else $error("top bits set");

  property p_status_sticky;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (irqSet != '0) |=>
        ((st_r.irqStat & $past(irqSet)) == $past(irqSet));
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status set lost");

  property p_wait_halt;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_WAIT && !tbRunning && !wrEn) |=> st_r.state == ST_WAIT;
  endproperty
  a_wait_halt: assert property (p_wait_halt) else $error("window opened while halted");

  property p_result_hold;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_IDLE && !wrEn) |=> $stable(st_r.result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved when idle");

  property p_resume_result;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (st_r.state == ST_LOST && oscTick && !wrEn)
        |=> st_r.result == $past(st_r.count) + 1'b1;
  endproperty
  a_resume_result: assert property (p_resume_result) else $error("resume result wrong");

  c_done: cover property (@(posedge clk_sys) disable iff (!rstSync_b)
    windowEnd && st_r.state == ST_RUN);
  c_lost: cover property (@(posedge clk_sys) disable iff (!rstSync_b)
    st_r.state == ST_LOST ##1 st_r.state == ST_IDLE);
  c_stop: cover property (@(posedge clk_sys) disable iff (!rstSync_b) swStop);
  c_start: cover property (@(posedge clk_sys) disable iff (!rstSync_b) swStart);
  c_irq:  cover property (@(posedge clk_sys) disable iff (!rstSync_b) $rose(irq));

endmodule : clock_supervisor_counter_ctrl

/* test/osc_source_model.sv */
`timescale 1ns/1ps
module osc_source_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] mainHalf,
  input  wire logic [7:0] subHalf,
  input  wire logic       mainStop,
  output logic            mainOsc,
  output logic            subOsc
);
  // ----------------------------------------
  // oscillators, main one can stall
  // ----------------------------------------
  logic [7:0] mainCnt_r = 8'h00;
  logic [7:0] subCnt_r  = 8'h00;
  logic       main_r    = 1'b0;
  logic       sub_r     = 1'b0;

  assign mainOsc = main_r;
  assign subOsc  = sub_r;

  // stalled clock stands still at its level
  always @(posedge clk_sys) begin
    if (!mainStop) begin
      mainCnt_r <= (mainCnt_r == mainHalf - 8'h01) ? 8'h00 : mainCnt_r + 8'h01;
      if (mainCnt_r == mainHalf - 8'h01) main_r <= ~main_r;
    end
    subCnt_r <= (subCnt_r == subHalf - 8'h01) ? 8'h00 : subCnt_r + 8'h01;
    if (subCnt_r == subHalf - 8'h01) sub_r <= ~sub_r;
  end
endmodule : osc_source_model

/* test/tb_clock_supervisor_counter_ctrl.sv */
`timescale 1ns/1ps
module tb_clock_supervisor_counter_ctrl;
  import csc_pkg::*;
  logic            clk_sys   = 1'b0;
  logic            rst_b     = 1'b0;
  logic            psel      = 1'b0;
  logic            penable   = 1'b0;
  logic            pwrite    = 1'b0;
  logic [7:0]      paddr     = 8'h00;
  logic [31:0]     pwdata    = 32'h0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            irq;
  logic            mainOsc;
  logic            subOsc;
  logic [TB_W-1:0] tbCount   = '0;
  logic [TB_W-1:0] tbStep    = 18'h1;
  logic            tbRunning = 1'b1;
  logic            mainStop  = 1'b0;
  logic [31:0]     rd;
  logic            errSeen;
  int              n_mismatch = 0;
  int              checks     = 0;
  int              cycles     = 0;

  clock_supervisor_counter_ctrl clock_supervisor_counter_ctrl_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tbCount(tbCount), .tbRunning(tbRunning), .mainOsc(mainOsc), .subOsc(subOsc), .irq(irq));

  osc_source_model osc_source_model_i (.clk_sys(clk_sys), .mainHalf(8'h02), .subHalf(8'h04),
    .mainStop(mainStop), .mainOsc(mainOsc), .subOsc(subOsc));

  // ----------------------------------------
  // clock, time base, run limit
  // ----------------------------------------
  initial forever #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (tbRunning) tbCount <= tbCount + tbStep;
    if (cycles == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                     input logic [31:0] got);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  function automatic logic [31:0] ctl(input logic [2:0] sel, input logic src, input logic en);
    return {26'h0, 1'b0, src, sel, en};
  endfunction : ctl

  task automatic waitGate(input int b, input logic v);
    while (tbCount[b] !== v) @(posedge clk_sys);
  endtask : waitGate

  task automatic waitDone();
    logic [31:0] r;
    do begin
      apb(1'b0, ADDR_RESULT, 32'h0);
      r = rd;
      apb(1'b0, ADDR_CONTROL, 32'h0);
      if (rd[CTL_EN_BIT] === 1'b1) chk("result busy", 0, 0, r);
    end while (rd[CTL_EN_BIT] !== 1'b0);
  endtask : waitDone

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic regs();
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("ctl reset", CTL_RESET, CTL_RESET, rd);
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("result reset", RESULT_RESET, RESULT_RESET, rd);
    apb(1'b1, ADDR_CONTROL, 32'h000000DE);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("ctl top bits", 32'h1E, 32'h1E, rd);
    apb(1'b1, ADDR_RESULT, 32'h000000FF);
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("result ro", 0, 0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 1, 1, errSeen);
    apb(1'b1, ADDR_CONTROL, 32'h0);
  endtask : regs

  task automatic irqs();
    apb(1'b1, ADDR_CONTROL, ctl(3'h0, 1'b0, 1'b1));
    waitDone();
    chk("irq masked", 0, 0, irq);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("done status", 1, 1, rd);
    apb(1'b1, ADDR_IRQ_EN, 32'h3);
    chk("irq raised", 1, 1, irq);
    apb(1'b1, ADDR_IRQ_CLR, 32'h1);
    chk("irq cleared", 0, 0, irq);
  endtask : irqs

  task automatic measure(input logic [2:0] sel);
    int per;
    int exp;
    per = (sel <= 2) ? (8 << (2 * sel)) : 128;
    exp = per / (sel[0] ? 8 : 4);
    tbStep <= (sel <= 2) ? 18'h1 : (18'h1 << (2 * sel - 4));
    apb(1'b1, ADDR_CONTROL, ctl(sel, sel[0], 1'b1));
    if (sel == 3'h2) begin
      apb(1'b1, ADDR_CONTROL, ctl(3'h5, 1'b1, 1'b1));
      apb(1'b0, ADDR_CONTROL, 32'h0);
      chk("ctl locked", ctl(sel, 1'b0, 1'b1), ctl(sel, 1'b0, 1'b1), rd);
    end
    waitDone();
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("count", exp - 1, exp + 1, rd);
    chk("done irq", 1, 1, irq);
    apb(1'b1, ADDR_IRQ_CLR, 32'h3);
  endtask : measure

  task automatic halt();
    tbStep <= 18'h1;
    waitGate(6, 1'b1);
    waitGate(6, 1'b0);
    apb(1'b1, ADDR_CONTROL, ctl(3'h2, 1'b0, 1'b1));
    waitGate(6, 1'b0);
    waitGate(6, 1'b1);
    repeat (20) @(posedge clk_sys);
    tbRunning <= 1'b0;
    repeat (64) @(posedge clk_sys);
    tbRunning <= 1'b1;
    waitDone();
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("halted count", 31, 33, rd);
    apb(1'b1, ADDR_IRQ_CLR, 32'h3);
  endtask : halt

  task automatic abort();
    apb(1'b1, ADDR_CONTROL, ctl(3'h2, 1'b0, 1'b1));
    waitGate(6, 1'b0);
    waitGate(6, 1'b1);
    repeat (20) @(posedge clk_sys);
    apb(1'b1, ADDR_CONTROL, ctl(3'h2, 1'b0, 1'b0));
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("ctl stopped", 4, 4, rd);
    repeat (300) @(posedge clk_sys);
    apb(1'b0, ADDR_RESULT, 32'h0);
    chk("result cleared", 0, 0, rd);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("no done after stop", 0, 0, rd);
  endtask : abort

  task automatic stall(input logic resume);
    mainStop <= 1'b1;
    waitGate(6, 1'b1);
    waitGate(6, 1'b0);
    apb(1'b1, ADDR_CONTROL, ctl(3'h2, 1'b0, 1'b1));
    waitGate(6, 1'b0);
    waitGate(6, 1'b1);
    waitGate(6, 1'b0);
    waitGate(6, 1'b1);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("ctl in stall", 5, 5, rd);
    if (resume) begin
      mainStop <= 1'b0;
      repeat (16) @(posedge clk_sys);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      chk("ctl after restart", 4, 4, rd);
    end else begin
      waitGate(6, 1'b0);
      repeat (4) @(posedge clk_sys);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      chk("ctl after fall", 4, 4, rd);
      apb(1'b0, ADDR_RESULT, 32'h0);
      chk("stall result", 0, 0, rd);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("lost status", 1, 1, rd[IRQ_LOST_BIT]);
      mainStop <= 1'b0;
    end
    apb(1'b1, ADDR_IRQ_CLR, 32'h3);
  endtask : stall

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    regs();
    irqs();
    for (int s = 0; s < 8; s++) measure(s[2:0]);
    halt();
    abort();
    stall(1'b1);
    stall(1'b0);
    stop_test();
  end
endmodule : tb_clock_supervisor_counter_ctrl
